/* include/pss_pkg.sv */
// package of constants and types for the power sequence and phase control block
package pss_pkg;
  localparam int          NUM_RES      = 6;
  localparam int          SEQ_DEPTH    = 8;
  localparam int          DLY_W        = 16;
  localparam int          CLK_MHZ      = 200;
  localparam int          RST_DLY_US   = 1;
  localparam int          RST_DLY_CYC  = RST_DLY_US * CLK_MHZ;
  localparam logic [15:0] RST_DLY_RST  = 16'(RST_DLY_CYC);
  localparam int          NUM_PH       = 4;
  localparam int          PH_PERIOD    = 40;
  localparam int          PH_SPACING   = PH_PERIOD / NUM_PH;
  localparam logic [7:0]  LOAD_ADD_TH  = 8'h80;
  localparam logic [7:0]  LOAD_SHED_TH = 8'h40;
  localparam logic [7:0]  LOAD_PWM_TH  = 8'h10;
  localparam logic [1:0]  ST_STANDBY   = 2'h0;
  localparam logic [1:0]  ST_ACTIVE    = 2'h1;
  localparam logic [1:0]  ST_MCU_ONLY  = 2'h2;
  localparam logic [1:0]  ST_DEEP_SLP  = 2'h3;
  localparam logic [3:0]  ADR_CTRL     = 4'h0;
  localparam logic [3:0]  ADR_STATUS   = 4'h1;
  localparam logic [3:0]  ADR_RSTDLY   = 4'h2;
  localparam logic [3:0]  ADR_USED     = 4'h3;
  localparam logic [3:0]  ADR_SEQ_IDX  = 4'h4;
  localparam logic [3:0]  ADR_SEQ_DAT  = 4'h5;
  localparam logic [3:0]  ADR_BUCK     = 4'h6;
  localparam int          CTL_MASK_B   = 0;
  localparam int          CTL_MON_B    = 1;
  localparam int          CTL_TGT_B    = 2;
  localparam int          CTL_NVM_B    = 4;
  localparam int          CTL_CLR_B    = 5;
  localparam int          BK_FPWM_B    = 0;
  localparam int          BK_FMP_B     = 1;
  typedef enum logic [5:0] {
    S_NOSUP  = 6'b000001,
    S_OFF    = 6'b000010,
    S_UP     = 6'b000100,
    S_RSTDLY = 6'b001000,
    S_ON     = 6'b010000,
    S_DOWN   = 6'b100000
  } pss_state_e;
endpackage

/* core/pss_ctrl.sv */
// power sequencer, supply-detect start-up and buck mode control
`timescale 1ns/10ps
module pss_ctrl (
  // clock, reset, enable
  input  wire logic                          I_MCLK,
  input  wire logic                          I_SRST,
  input  wire logic                          I_CE,
  // register port
  input  wire logic [3:0]                    I_ADDR,
  input  wire logic [31:0]                   I_WDATA,
  input  wire logic                          I_WR,
  input  wire logic                          I_RD,
  output logic      [31:0]                   O_RDATA,
  // requests and pins
  input  wire logic                          I_ON_REQ,
  input  wire logic                          I_OFF_REQ,
  input  wire logic                          I_ENABLE_PIN,
  input  wire logic                          I_ENABLE_ON_GPIO,
  input  wire logic                          I_SUPPLY_PRESENT,
  input  wire logic                          I_UV_OK,
  input  wire logic                          I_SLEEP_REQUEST_ONE,
  input  wire logic                          I_SLEEP_REQUEST_TWO,
  input  wire logic [7:0]                    I_LOAD_LEVEL,
  // outputs
  output logic      [pss_pkg::NUM_RES-1:0]   O_RES_EN,
  output logic                               O_MCU_RESET_OUTPUT_N,
  output logic                               O_SOC_RESET_OUTPUT_N,
  output logic                               O_SUPPLY_DETECT_EVENT_FLAG,
  output logic      [1:0]                    O_OP_STATE,
  output logic                               O_SEQ_DONE,
  output logic                               O_PWM_MODE,
  output logic      [pss_pkg::NUM_PH-1:0]    O_PHASE_EN,
  output logic      [pss_pkg::NUM_PH-1:0]    O_PHASE_PULSE
);
  import pss_pkg::*;

  pss_state_e                 state;
  logic [NUM_RES-1:0]         seq_res [SEQ_DEPTH];
  logic [DLY_W-1:0]           seq_dly [SEQ_DEPTH];
  logic [2:0]                 seq_idx;
  logic [2:0]                 step;
  logic [2:0]                 last_step;
  logic [DLY_W-1:0]           cnt;
  logic [15:0]                rst_dly;
  logic [NUM_RES-1:0]         used;
  logic [NUM_RES-1:0]         seq_out;
  logic [NUM_RES-1:0]         mcu_res;
  logic                       supply_detect_autostart_mask;
  logic                       input_supply_monitor_enable;
  logic [1:0]                 startup_target_state;
  logic                       nvm_loaded;
  logic                       forced_pwm_select;
  logic                       forced_multiphase_select;
  logic                       clr_flag;
  logic [2:0]                 en_sy, s1_sy, s2_sy, uv_sy, sp_sy;
  logic                       en_f, s1_f, s2_f, uv_f, sp_f;
  logic                       armed;
  logic [5:0]                 ph_cnt;
  logic [2:0]                 nph;

  // filtered pin: second and third stage agree, else hold
  function automatic logic filt(input logic [2:0] sy, input logic prev);
    filt = (sy[1] == sy[2]) ? sy[2] : prev;
  endfunction

  function automatic logic [1:0] sleep_target(input logic s1, input logic s2);
    if (s1 && s2) begin
      sleep_target = ST_ACTIVE;
    end else if (s2) begin
      sleep_target = ST_MCU_ONLY;
    end else begin
      sleep_target = ST_DEEP_SLP;
    end
  endfunction

  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      en_sy <= 3'h0;
      s1_sy <= 3'h0;
      s2_sy <= 3'h0;
      uv_sy <= 3'h0;
      sp_sy <= 3'h0;
      en_f  <= 1'b0;
      s1_f  <= 1'b0;
      s2_f  <= 1'b0;
      uv_f  <= 1'b0;
      sp_f  <= 1'b0;
    end else if (I_CE) begin
      en_sy <= {en_sy[1:0], I_ENABLE_PIN};
      s1_sy <= {s1_sy[1:0], I_SLEEP_REQUEST_ONE};
      s2_sy <= {s2_sy[1:0], I_SLEEP_REQUEST_TWO};
      uv_sy <= {uv_sy[1:0], I_UV_OK};
      sp_sy <= {sp_sy[1:0], I_SUPPLY_PRESENT};
      en_f  <= filt(en_sy, en_f);
      s1_f  <= filt(s1_sy, s1_f);
      s2_f  <= filt(s2_sy, s2_f);
      uv_f  <= filt(uv_sy, uv_f);
      sp_f  <= filt(sp_sy, sp_f);
    end
  end

  assign armed = !supply_detect_autostart_mask && (!I_ENABLE_ON_GPIO || en_f);

  // register writes
  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      supply_detect_autostart_mask <= 1'b1;
      input_supply_monitor_enable  <= 1'b0;
      startup_target_state         <= ST_ACTIVE;
      nvm_loaded                   <= 1'b0;
      rst_dly                      <= RST_DLY_RST;
      used                         <= '0;
      seq_idx                      <= 3'h0;
      mcu_res                      <= '0;
      forced_pwm_select            <= 1'b0;
      forced_multiphase_select     <= 1'b0;
      for (int i = 0; i < SEQ_DEPTH; i++) begin
        seq_res[i] <= '0;
        seq_dly[i] <= '0;
      end
    end else if (I_CE && I_WR) begin
      case (I_ADDR)
        ADR_CTRL: begin
          supply_detect_autostart_mask <= I_WDATA[CTL_MASK_B];
          input_supply_monitor_enable  <= I_WDATA[CTL_MON_B];
          startup_target_state         <= I_WDATA[CTL_TGT_B +: 2];
          nvm_loaded                   <= I_WDATA[CTL_NVM_B] | nvm_loaded;
        end
        ADR_RSTDLY:  rst_dly <= I_WDATA[15:0];
        ADR_USED: begin
          used    <= I_WDATA[NUM_RES-1:0];
          mcu_res <= I_WDATA[8 +: NUM_RES];
        end
        ADR_SEQ_IDX: seq_idx <= I_WDATA[2:0];
        ADR_SEQ_DAT: begin
          seq_dly[seq_idx] <= I_WDATA[DLY_W-1:0];
          seq_res[seq_idx] <= I_WDATA[16 +: NUM_RES];
        end
        ADR_BUCK: begin
          forced_pwm_select        <= I_WDATA[BK_FPWM_B];
          forced_multiphase_select <= I_WDATA[BK_FMP_B];
        end
        default: begin
        end
      endcase
    end
  end

  assign clr_flag = I_CE && I_WR && (I_ADDR == ADR_CTRL) && I_WDATA[CTL_CLR_B];
  assign last_step = 3'(SEQ_DEPTH - 1);

  // main sequencer
  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      state                      <= S_NOSUP;
      step                       <= 3'h0;
      cnt                        <= '0;
      seq_out                    <= '0;
      O_OP_STATE                 <= ST_STANDBY;
      O_SEQ_DONE                 <= 1'b0;
      O_SUPPLY_DETECT_EVENT_FLAG <= 1'b0;
      O_MCU_RESET_OUTPUT_N       <= 1'b0;
      O_SOC_RESET_OUTPUT_N       <= 1'b0;
    end else if (I_CE) begin
      case (state)
        S_NOSUP: begin
          if (nvm_loaded && sp_f) begin
            if (armed && uv_f && input_supply_monitor_enable) begin
              O_OP_STATE                 <= startup_target_state;
              O_SUPPLY_DETECT_EVENT_FLAG <= 1'b1;
              state                      <= S_UP;
              step                       <= 3'h0;
              cnt                        <= seq_dly[0];
            end else if (!armed || !input_supply_monitor_enable) begin
              state <= S_OFF;
            end
          end
        end
        S_OFF: begin
          if (I_ON_REQ) begin
            O_OP_STATE <= ST_ACTIVE;
            state      <= S_UP;
            step       <= 3'h0;
            cnt        <= seq_dly[0];
            O_SEQ_DONE <= 1'b0;
          end
        end
        S_UP, S_DOWN: begin
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else begin
            if (state == S_UP) begin
              seq_out <= seq_out | seq_res[step];
            end else begin
              seq_out <= seq_out & ~seq_res[step];
            end
            if (step == last_step) begin
              if (state == S_UP) begin
                state <= S_RSTDLY;
                cnt   <= rst_dly;
              end else begin
                state      <= S_OFF;
                O_OP_STATE <= ST_STANDBY;
                O_SEQ_DONE <= 1'b1;
              end
            end else begin
              step <= step + 1'b1;
              cnt  <= seq_dly[step + 1'b1];
            end
          end
        end
        S_RSTDLY: begin
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else begin
            O_MCU_RESET_OUTPUT_N <= 1'b1;
            O_SOC_RESET_OUTPUT_N <= 1'b1;
            O_SEQ_DONE           <= 1'b1;
            state                <= S_ON;
          end
        end
        S_ON: begin
          if (I_OFF_REQ) begin
            O_MCU_RESET_OUTPUT_N <= 1'b0;
            O_SOC_RESET_OUTPUT_N <= 1'b0;
            O_SEQ_DONE           <= 1'b0;
            state                <= S_DOWN;
            step                 <= 3'h0;
            cnt                  <= seq_dly[0];
          end else if (clr_flag && O_SUPPLY_DETECT_EVENT_FLAG) begin
            O_OP_STATE                 <= sleep_target(s1_f, s2_f);
            O_SUPPLY_DETECT_EVENT_FLAG <= 1'b0;
          end
        end
        default: state <= S_NOSUP;
      endcase
    end
  end

  // unused resources stay off until completion, then MCU may drive them
  always_comb begin
    O_RES_EN = (seq_out & used) | (O_SEQ_DONE ? (mcu_res & ~used) : '0);
  end

  // buck mode: PWM decision and phase count
  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      O_PWM_MODE <= 1'b0;
      nph        <= 3'h1;
    end else if (I_CE) begin
      O_PWM_MODE <= forced_pwm_select || forced_multiphase_select
                    || (I_LOAD_LEVEL >= LOAD_PWM_TH);
      if (forced_multiphase_select) begin
        nph <= 3'(NUM_PH);
      end else if (!O_PWM_MODE) begin
        nph <= 3'h1;
      end else if (I_LOAD_LEVEL >= LOAD_ADD_TH && nph < 3'(NUM_PH)) begin
        nph <= nph + 1'b1;
      end else if (I_LOAD_LEVEL < LOAD_SHED_TH && nph > 3'h1) begin
        nph <= nph - 1'b1;
      end
    end
  end

  // interleave: phase k fires at k quarter periods
  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      ph_cnt        <= 6'h0;
      O_PHASE_EN    <= '0;
      O_PHASE_PULSE <= '0;
    end else if (I_CE) begin
      ph_cnt <= (ph_cnt == 6'(PH_PERIOD - 1)) ? 6'h0 : ph_cnt + 1'b1;
      for (int k = 0; k < NUM_PH; k++) begin
        O_PHASE_EN[k]    <= (3'(k) < nph) && O_PWM_MODE;
        O_PHASE_PULSE[k] <= (ph_cnt == 6'(k * PH_SPACING)) && (3'(k) < nph)
                            && O_PWM_MODE;
      end
    end
  end

  // register reads
  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      O_RDATA <= 32'h0;
    end else if (I_CE && I_RD) begin
      case (I_ADDR)
        ADR_CTRL:   O_RDATA <= {26'h0, 1'b0, nvm_loaded, startup_target_state,
                                input_supply_monitor_enable, supply_detect_autostart_mask};
        ADR_STATUS: O_RDATA <= {18'h0, state, 1'b0, step, O_SUPPLY_DETECT_EVENT_FLAG,
                                O_SEQ_DONE, O_OP_STATE};
        ADR_RSTDLY: O_RDATA <= {16'h0, rst_dly};
        ADR_USED:   O_RDATA <= {18'h0, mcu_res, 2'h0, used};
        ADR_SEQ_IDX: O_RDATA <= {29'h0, seq_idx};
        ADR_SEQ_DAT: O_RDATA <= {10'h0, seq_res[seq_idx], seq_dly[seq_idx]};
        ADR_BUCK:   O_RDATA <= {25'h0, nph, 2'h0, forced_multiphase_select, forced_pwm_select};
        default:    O_RDATA <= 32'h0;
      endcase
    end
  end

  property p_reset_after_seq;
    @(posedge I_MCLK) disable iff (I_SRST)
      $rose(O_MCU_RESET_OUTPUT_N) |-> $past(state) == S_RSTDLY && O_SOC_RESET_OUTPUT_N;
  endproperty
  a_reset_after_seq: assert property (p_reset_after_seq) else $error("reset released early");

  property p_up_only_on;
    @(posedge I_MCLK) disable iff (I_SRST)
      (state == S_OFF && I_CE && !I_ON_REQ) |=> state != S_UP;
  endproperty
  a_up_only_on: assert property (p_up_only_on) else $error("up without on request");

  property p_down_on_off;
    @(posedge I_MCLK) disable iff (I_SRST)
      (state == S_ON && I_CE && I_OFF_REQ) |=> state == S_DOWN;
  endproperty
  a_down_on_off: assert property (p_down_on_off) else $error("off request ignored");

  property p_unused_off;
    @(posedge I_MCLK) disable iff (I_SRST)
      !O_SEQ_DONE |-> (O_RES_EN & ~used) == '0;
  endproperty
  a_unused_off: assert property (p_unused_off) else $error("unused resource on");

  property p_nvm_gate;
    @(posedge I_MCLK) disable iff (I_SRST)
      (state == S_NOSUP && !nvm_loaded) |=> state == S_NOSUP;
  endproperty
  a_nvm_gate: assert property (p_nvm_gate) else $error("left no-supply before load");

  property p_fpwm;
    @(posedge I_MCLK) disable iff (I_SRST)
      (forced_pwm_select && I_CE) |=> O_PWM_MODE;
  endproperty
  a_fpwm: assert property (p_fpwm) else $error("pfm while forced pwm");

  property p_fmp;
    @(posedge I_MCLK) disable iff (I_SRST)
      (forced_multiphase_select && I_CE) [*2] |=> O_PHASE_EN == '1;
  endproperty
  a_fmp: assert property (p_fmp) else $error("phase off in forced multiphase");

  property p_step_delay;
    @(posedge I_MCLK) disable iff (I_SRST)
      ((state == S_UP) && I_CE && cnt != '0) |=> $stable(seq_out);
  endproperty
  a_step_delay: assert property (p_step_delay) else $error("step applied before delay");
endmodule

/* verif/pss_mcu_model.sv */
// model of the attached controller driving the two sleep request pins
`timescale 1ns/10ps
module pss_mcu_model (
  // clock and command from the bench
  input  wire logic       i_clk,
  input  wire logic       i_go,
  input  wire logic [1:0] i_want,
  input  wire logic [3:0] i_lag,
  // sleep pins towards the device, ready flag back to the bench
  output logic      [1:0] o_sleep = 2'h3,
  output logic            o_ready = 1'b0
);
  int cnt = 0;

  // levels go out first; the flag clear is allowed only after they settle
  always @(posedge i_clk) begin
    if (i_go) begin
      o_sleep <= i_want;
      o_ready <= 1'b0;
      cnt     <= 6 + i_lag;
    end else if (cnt > 0) begin
      cnt     <= cnt - 1;
      o_ready <= (cnt == 1);
    end
  end
endmodule

/* verif/tb.sv */
// self-checking bench for the power sequencer and buck mode control
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module tb;
  import pss_pkg::*;
  logic        mclk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, on_req = 1'b0, off_req = 1'b0;
  logic        sup = 1'b0, uv_ok = 1'b0, pin = 1'b1, go = 1'b0, ph_chk = 1'b0;
  logic [3:0]  addr = 4'h0, lag = 4'h0, ph_en, ph_pls;
  logic [31:0] wdata = 32'h0, rdat;
  logic [7:0]  load = 8'h00;
  logic [1:0]  want = 2'h0, slp, op_st;
  logic        ready, mrst_n, srst_n, flag, done, pwm;
  logic [5:0]  res_en;
  int          errors = 0, n_compared = 0, dly[8], ent[8], used, direct, rdly, m, n, cyc = 0;
  int          ph_t[4];

  always #2.5 mclk = ~mclk;

  pss_ctrl dut (.I_MCLK(mclk), .I_SRST(srst), .I_CE(1'b1), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdat), .I_ON_REQ(on_req), .I_OFF_REQ(off_req),
    .I_ENABLE_PIN(pin), .I_ENABLE_ON_GPIO(1'b1), .I_SUPPLY_PRESENT(sup), .I_UV_OK(uv_ok),
    .I_SLEEP_REQUEST_ONE(slp[0]), .I_SLEEP_REQUEST_TWO(slp[1]), .I_LOAD_LEVEL(load),
    .O_RES_EN(res_en), .O_MCU_RESET_OUTPUT_N(mrst_n), .O_SOC_RESET_OUTPUT_N(srst_n),
    .O_SUPPLY_DETECT_EVENT_FLAG(flag), .O_OP_STATE(op_st), .O_SEQ_DONE(done),
    .O_PWM_MODE(pwm), .O_PHASE_EN(ph_en), .O_PHASE_PULSE(ph_pls));

  pss_mcu_model mcu (.i_clk(mclk), .i_go(go), .i_want(want), .i_lag(lag), .o_sleep(slp),
    .o_ready(ready));

  task automatic close_out;
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask

  task automatic do_reset;
    @(posedge mclk);
    srst <= 1'b1;
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
  endtask

  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [31:0] msk, input logic [31:0] e);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    `CHK(rdat & msk, e)
  endtask

  task automatic pulse(input bit off);
    @(posedge mclk);
    if (off) off_req <= 1'b1; else on_req <= 1'b1;
    @(posedge mclk);
    off_req <= 1'b0;
    on_req <= 1'b0;
  endtask

  // reference walk: entry k lands dly[k]+1 cycles after entry k-1
  task automatic walk(input bit up);
    int k, t;
    #1;
    n = 0;
    while (res_en === 6'(m) && n < 100) begin
      tick(1);
      n++;
    end
    t = 0;
    k = 0;
    for (n = 0; k < 8; n++) begin
      while (k < 8 && t <= n) begin
        m = up ? (m | (ent[k] & used)) : (m & ~ent[k]);
        k++;
        if (k < 8) t += dly[k] + 1;
      end
      `CHK(res_en, 6'(m))
      if (k < 8) tick(1);
    end
  endtask

  // neighbouring phases must fire a fixed spacing apart
  always @(posedge mclk) begin
    cyc++;
    for (int j = 0; j < NUM_PH; j++)
      if (ph_chk && ph_pls[j] === 1'b1) begin
        if (j > 0 && ph_t[j-1] >= 0) `CHK(cyc - ph_t[j-1], PH_SPACING)
        ph_t[j] = cyc;
      end
  end

  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    $display("Error at %0t: watchdog expired", $time);
    close_out();
  end

  initial begin
    void'($urandom(32'hB57C));
    do_reset();
    tick(2);
    `CHK(mrst_n, 1'b0)
    rchk(ADR_CTRL, 32'h1F, 32'h5);
    rchk(ADR_RSTDLY, 32'hFFFF, 32'(RST_DLY_RST));
    wreg(4'hF, 32'hFFFF_FFFF);
    rchk(4'hF, 32'hFFFF_FFFF, 32'h0);
    pulse(1'b0);
    tick(20);
    `CHK(res_en, 6'h00)
    used = $urandom_range(63, 0) | 1;
    direct = $urandom_range(63, 0) & ~used;
    rdly = $urandom_range(9, 2);
    for (int k = 0; k < 8; k++) begin
      dly[k] = $urandom_range(7, 0);
      ent[k] = $urandom_range(63, 0) | (k == 0);
      wreg(ADR_SEQ_IDX, k);
      wreg(ADR_SEQ_DAT, (ent[k] << 16) | dly[k]);
    end
    rchk(ADR_SEQ_DAT, 32'h3F_FFFF, (ent[7] << 16) | dly[7]);
    wreg(ADR_USED, used);
    wreg(ADR_RSTDLY, rdly);
    rchk(ADR_RSTDLY, 32'hFFFF, rdly);
    wreg(ADR_CTRL, 32'h17);
    sup <= 1'b1;
    uv_ok <= 1'b1;
    tick(20);
    rchk(ADR_STATUS, 32'h3F00, {S_OFF, 8'h00});
    m = 0;
    pulse(1'b0);
    walk(1'b1);
    n = 0;
    while (mrst_n !== 1'b1 && n < 300) begin
      tick(1);
      n++;
    end
    `CHK(n >= rdly + 1 && n <= rdly + 3, 1'b1)
    `CHK(srst_n, 1'b1)
    `CHK(done, 1'b1)
    wreg(ADR_USED, used | (direct << 8));
    tick(3);
    `CHK(res_en, 6'(m | direct))
    wreg(ADR_USED, used);
    tick(3);
    pulse(1'b1);
    #1;
    `CHK({mrst_n, srst_n}, 2'b00)
    walk(1'b0);
    `CHK(res_en, 6'h00)
    // enable pin inactive: supply detect must not arm
    pin <= 1'b0;
    do_reset();
    wreg(ADR_CTRL, 32'h1A);
    tick(30);
    rchk(ADR_STATUS, 32'h3F08, {S_OFF, 8'h00});
    pin <= 1'b1;
    // each pass starts afresh from no supply so the detect flag is set again
    for (int s = 0; s < 4; s++) begin
      uv_ok <= 1'b0;
      do_reset();
      wreg(ADR_CTRL, 32'h0A);
      tick(30);
      `CHK(flag, 1'b0)
      wreg(ADR_CTRL, 32'h1A);
      tick(30);
      `CHK(flag, 1'b0)
      @(posedge mclk);
      uv_ok <= 1'b1;
      n = 0;
      while (flag !== 1'b1 && n < 30) begin
        tick(1);
        n++;
      end
      `CHK(op_st, ST_MCU_ONLY)
      n = 0;
      while (mrst_n !== 1'b1 && n < 400) begin
        tick(1);
        n++;
      end
      `CHK(mrst_n, 1'b1)
      @(posedge mclk);
      want <= 2'(s);
      lag <= 4'($urandom_range(15, 0));
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      tick(2);
      n = 0;
      while (ready !== 1'b1 && n < 40) begin
        tick(1);
        n++;
      end
      wreg(ADR_CTRL, 32'h3A);
      tick(3);
      `CHK(op_st, s == 3 ? ST_ACTIVE : s == 2 ? ST_MCU_ONLY : ST_DEEP_SLP)
      `CHK(flag, 1'b0)
    end
    wreg(ADR_BUCK, 32'h1);
    tick(8);
    `CHK(pwm, 1'b1)
    wreg(ADR_BUCK, 32'h0);
    tick(40);
    `CHK(pwm, 1'b0)
    @(posedge mclk);
    load <= 8'($urandom_range(255, 128));
    tick(300);
    `CHK({pwm, ph_en}, 5'h1F)
    @(posedge mclk);
    load <= 8'h20;
    tick(300);
    `CHK(ph_en !== 4'hF, 1'b1)
    wreg(ADR_BUCK, 32'h2);
    load <= 8'h00;
    tick(100);
    `CHK({pwm, ph_en}, 5'h1F)
    ph_t = '{-1, -1, -1, -1};
    ph_chk = 1'b1;
    tick(200);
    ph_chk = 1'b0;
    close_out();
  end
endmodule
